// ===== src/spm_monitor.sv
// subroutine performance monitor: per-channel time and count over prefetch addresses
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (RULE1) decisions use prefetch addresses only
// (RULE2) accumulate only during free run
// (RULE3) range gated mode times inside range
// (RULE4) calls outside range not timed
// (RULE5) count end fetch after start passed
// (RULE6) entry exit mode: start to end
// (RULE7) entry exit includes called routines
// (RULE8) range pair: entry range to exit range
// (RULE9) range pair counts exit after start
// (RULE10) eight channels, four with range pair
// (RULE11) range pair only odd channels
// (RULE12) channel one timeout break in trace run; not raised while channel one is in range pair mode
// (RULE13) channel one count limit break; not raised while channel one is in range pair mode
// (RULE14) count limit 1 to FFFF
// (RULE15) limit checked at end address
// (RULE16) cancel one channel or all
// (RULE17) initialize clears all accumulators
// (RULE18) total time runs only when assigned
// (RULE19) physical or translated virtual compare
// (RULE20) host avoids setup during stepping
// (RULE21) host avoids unexecuted end addresses
// (RULE22) timeout in microseconds, channel one only
// (RULE23) time advances per tick while active
// (RULE24) results readable while stopped
module spm_monitor
    import spm_pkg::*;
#(
    parameter int unsigned NCH = SPM_NCH,
    parameter int unsigned TICK_NS = 1000
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // target prefetch bus and run state
    input wire spm_fetch_t i_fetch,
    input wire logic i_free_run,
    input wire logic i_trace_break_run_mode,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // break request
    output logic o_break_req
);
    localparam int unsigned TICK_CYC_RAW = (TICK_NS * SPM_CLK_MHZ) / 1000;
    localparam int unsigned TICK_CYC = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;

    // parameter checks at elaboration
    if (NCH < 1 || NCH > SPM_NCH)
    begin : g_bad_nch
        $error("channel count out of range");
    end
    // the tick divider counts in sixteen bits
    if (TICK_CYC > 32'h0000FFFF)
    begin : g_bad_tick
        $error("tick period too long for divider");
    end

    spm_chcfg_t cfg_q [SPM_NCH];
    logic [SPM_TIME_W-1:0] time_q [SPM_NCH];
    logic [SPM_CNT_W-1:0] cnt_q [SPM_NCH];
    logic [SPM_NCH-1:0] active_q;
    logic [SPM_NCH-1:0] armed_q;
    logic [SPM_TIME_W-1:0] total_q;
    logic [SPM_TIME_W-1:0] tmo_q;
    logic [15:0] limit_q;
    logic tmo_en_q;
    logic lim_en_q;
    logic [15:0] tick_cnt_q;
    logic tick;
    logic any_assigned;
    logic init_req;
    logic [SPM_NCH-1:0] cancel_mask;
    logic [2:0] rd_idx;

    function automatic logic in_rng(input logic [SPM_ADDR_W-1:0] a,
                                    input logic [SPM_ADDR_W-1:0] lo,
                                    input logic [SPM_ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic is_ctrl(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // channel number sits in the middle bits of the word index
    function automatic logic [2:0] ch_idx(input logic [7:0] a);
        return a[5:3];
    endfunction

    // register writes decoded
    logic wr_ch;
    logic [2:0] wr_idx;
    logic [2:0] wr_fld;
    assign wr_ch = i_wr && (i_addr >= SPM_CH_BASE) && (i_addr[7:6] == SPM_CH_BASE[7:6]);
    assign wr_idx = ch_idx(i_addr);
    assign rd_idx = ch_idx(i_addr);
    assign wr_fld = i_addr[2:0];
    assign init_req = i_wr && is_ctrl(i_addr, SPM_REG_CTRL) && i_wdata[SPM_CTRL_INIT];

    always_comb
    begin
        cancel_mask = '0;
        if (i_wr && is_ctrl(i_addr, SPM_REG_CTRL))
        begin
            if (i_wdata[SPM_CTRL_CANALL])
                cancel_mask = '1; // RULE16
            else if (i_wdata[SPM_CTRL_CANCEL])
                cancel_mask[i_wdata[SPM_CTRL_CHLO +: 3]] = 1'b1; // RULE16
        end
    end

    always_comb
    begin
        any_assigned = 1'b0;
        for (int i = 0; i < SPM_NCH; i++)
            any_assigned = any_assigned | cfg_q[i].en;
    end

    // measurement tick
    // one unit per TICK_NS; shorter periods tick every cycle
    assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tick_cnt_q <= 16'h0000;
        else if (i_ce)
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    // channel configuration
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < SPM_NCH; i++)
                cfg_q[i] <= '0;
        end
        else if (i_ce)
        begin
            // cancel only drops enable; addresses stay for reuse
            for (int i = 0; i < SPM_NCH; i++)
                if (cancel_mask[i])
                    cfg_q[i].en <= 1'b0;
            if (wr_ch && (32'(wr_idx) < NCH))
            begin
                unique case (wr_fld)
                    SPM_CH_CFG:
                    begin
                        cfg_q[wr_idx].en <= i_wdata[SPM_CFG_EN];
                        // range pair refused on even-numbered channels
                        if (wr_idx[0] && spm_mode_t'(i_wdata[SPM_CFG_MODE +: 2]) == SPM_MODE_RANGE_PAIR)
                            cfg_q[wr_idx].mode <= SPM_MODE_ENTRY_EXIT; // RULE11 RULE10
                        else
                            cfg_q[wr_idx].mode <= spm_mode_t'(i_wdata[SPM_CFG_MODE +: 2]);
                        cfg_q[wr_idx].phys <= i_wdata[SPM_CFG_PHYS];
                    end
                    SPM_CH_A0: cfg_q[wr_idx].a0 <= i_wdata;
                    SPM_CH_A1: cfg_q[wr_idx].a1 <= i_wdata;
                    SPM_CH_B0: cfg_q[wr_idx].b0 <= i_wdata;
                    SPM_CH_B1: cfg_q[wr_idx].b1 <= i_wdata;
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // channel one limits and control
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tmo_q <= '0;
            limit_q <= SPM_LIMIT_RST;
            tmo_en_q <= 1'b0;
            lim_en_q <= 1'b0;
        end
        else if (i_ce && i_wr)
        begin
            if (is_ctrl(i_addr, SPM_REG_CTRL))
            begin
                tmo_en_q <= i_wdata[SPM_CTRL_TMOEN];
                lim_en_q <= i_wdata[SPM_CTRL_LIMEN];
            end
            if (is_ctrl(i_addr, SPM_REG_TMO_LO))
                tmo_q[31:0] <= i_wdata; // RULE22
            if (is_ctrl(i_addr, SPM_REG_TMO_HI))
                tmo_q[SPM_TIME_W-1:32] <= i_wdata[SPM_TIME_W-33:0]; // RULE22
            // a zero limit is refused and the old one kept
            if (is_ctrl(i_addr, SPM_REG_LIMIT) && i_wdata[15:0] >= SPM_LIMIT_MIN)
                limit_q <= i_wdata[15:0]; // RULE14
        end
    end

    // per-channel state machines and accumulators
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            active_q <= '0;
            armed_q <= '0;
            for (int i = 0; i < SPM_NCH; i++)
            begin
                time_q[i] <= '0;
                cnt_q[i] <= '0;
            end
        end
        else if (i_ce)
        begin
            for (int i = 0; i < SPM_NCH; i++)
            begin
                logic [SPM_ADDR_W-1:0] a;
                logic ia;
                logic ib;
                logic hit_s;
                logic hit_e;
                logic run;
                a = cfg_q[i].phys ? i_fetch.paddr : i_fetch.vaddr; // RULE19
                ia = in_rng(a, cfg_q[i].a0, cfg_q[i].a1);
                ib = in_rng(a, cfg_q[i].b0, cfg_q[i].b1);
                hit_s = (a == cfg_q[i].a0);
                hit_e = (a == cfg_q[i].a1);
                run = cfg_q[i].en && i_free_run && i_fetch.valid; // RULE1 RULE2
                if (run)
                begin
                    unique case (cfg_q[i].mode)
                        SPM_MODE_RANGE_GATED:
                        begin
                            active_q[i] <= ia; // RULE3 RULE4
                            if (hit_s)
                                armed_q[i] <= 1'b1;
                            if (hit_e && (armed_q[i] || hit_s))
                            begin
                                cnt_q[i] <= cnt_q[i] + 1'b1; // RULE5
                                armed_q[i] <= 1'b0;
                            end
                        end
                        SPM_MODE_ENTRY_EXIT:
                        begin
                            if (hit_s)
                            begin
                                active_q[i] <= 1'b1; // RULE6 RULE7
                                armed_q[i] <= 1'b1;
                            end
                            else if (hit_e && armed_q[i])
                            begin
                                active_q[i] <= 1'b0; // RULE6
                                armed_q[i] <= 1'b0;
                                cnt_q[i] <= cnt_q[i] + 1'b1; // RULE5
                            end
                        end
                        SPM_MODE_RANGE_PAIR:
                        begin
                            if (ia)
                            begin
                                active_q[i] <= 1'b1; // RULE8
                                armed_q[i] <= 1'b1;
                            end
                            else if (ib && armed_q[i])
                            begin
                                active_q[i] <= 1'b0; // RULE8
                                armed_q[i] <= 1'b0;
                                cnt_q[i] <= cnt_q[i] + 1'b1; // RULE9
                            end
                        end
                        SPM_MODE_OFF:
                            active_q[i] <= 1'b0;
                    endcase
                end
                if (!cfg_q[i].en)
                begin
                    active_q[i] <= 1'b0;
                    armed_q[i] <= 1'b0;
                end
                if (tick && i_free_run && active_q[i] && cfg_q[i].en)
                    time_q[i] <= time_q[i] + 1'b1; // RULE23 RULE2
                // init last so it beats a same-cycle count
                if (init_req)
                begin
                    time_q[i] <= '0; // RULE17
                    cnt_q[i] <= '0; // RULE17
                end
            end
        end
    end

    // total run time
    // total follows channel assignment, not the target alone
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            total_q <= '0;
        else if (i_ce)
        begin
            if (init_req)
                total_q <= '0; // RULE17
            else if (tick && i_free_run && any_assigned)
                total_q <= total_q + 1'b1; // RULE18
        end
    end

    // channel one break request, sticky until cleared
    // set after clear: a hit in the clearing cycle wins
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_break_req <= 1'b0;
        else if (i_ce)
        begin
            if (i_wr && is_ctrl(i_addr, SPM_REG_CTRL) && i_wdata[SPM_CTRL_CLRBRK])
                o_break_req <= 1'b0;
            if (i_trace_break_run_mode && cfg_q[0].en && cfg_q[0].mode != SPM_MODE_RANGE_PAIR)
            begin
                if (tmo_en_q && time_q[0] > tmo_q)
                    o_break_req <= 1'b1; // RULE12
                if (lim_en_q && cnt_q[0] > SPM_CNT_W'(limit_q))
                    o_break_req <= 1'b1; // RULE13 RULE15
            end
        end
    end

    // read port, one cycle latency
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= SPM_ZERO;
        else if (i_ce)
        begin
            o_rdata <= SPM_ZERO;
            if (i_rd)
            begin
                if (i_addr[7:6] == SPM_CH_BASE[7:6])
                begin
                    // channels at or above NCH read back their reset values
                    unique case (i_addr[2:0])
                        SPM_CH_CFG: o_rdata <= {28'h0000000, cfg_q[rd_idx].phys,
                            cfg_q[rd_idx].mode, cfg_q[rd_idx].en};
                        SPM_CH_A0: o_rdata <= cfg_q[rd_idx].a0;
                        SPM_CH_A1: o_rdata <= cfg_q[rd_idx].a1;
                        SPM_CH_B0: o_rdata <= cfg_q[rd_idx].b0;
                        SPM_CH_B1: o_rdata <= cfg_q[rd_idx].b1;
                        SPM_CH_TLO: o_rdata <= time_q[rd_idx][31:0]; // RULE24
                        SPM_CH_THI: o_rdata <= 32'(time_q[rd_idx][SPM_TIME_W-1:32]);
                        SPM_CH_CNT: o_rdata <= cnt_q[rd_idx]; // RULE24
                    endcase
                end
                else if (is_ctrl(i_addr, SPM_REG_CTRL))
                    o_rdata <= {26'h0000000, lim_en_q, tmo_en_q, 4'h0};
                else if (is_ctrl(i_addr, SPM_REG_STAT))
                    o_rdata <= {22'h000000, active_q, any_assigned, o_break_req};
                else if (is_ctrl(i_addr, SPM_REG_TOT_LO))
                    o_rdata <= total_q[31:0]; // RULE24
                else if (is_ctrl(i_addr, SPM_REG_TOT_HI))
                    o_rdata <= 32'(total_q[SPM_TIME_W-1:32]);
                else if (is_ctrl(i_addr, SPM_REG_TMO_LO))
                    o_rdata <= tmo_q[31:0];
                else if (is_ctrl(i_addr, SPM_REG_TMO_HI))
                    o_rdata <= 32'(tmo_q[SPM_TIME_W-1:32]);
                else if (is_ctrl(i_addr, SPM_REG_LIMIT))
                    o_rdata <= {16'h0000, limit_q};
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/spm_pkg.sv
// package for the subroutine performance monitor
package spm_pkg;
    localparam int unsigned SPM_CLK_MHZ = 200;
    localparam int unsigned SPM_ADDR_W = 32;
    localparam int unsigned SPM_NCH = 8;
    localparam int unsigned SPM_TIME_W = 48;
    localparam int unsigned SPM_CNT_W = 32;
    // register map: word index = addr[7:0], ch in addr[5:3], field in addr[2:0]
    localparam logic [7:0] SPM_REG_CTRL = 8'h00;
    localparam logic [7:0] SPM_REG_STAT = 8'h01;
    localparam logic [7:0] SPM_REG_TOT_LO = 8'h02;
    localparam logic [7:0] SPM_REG_TOT_HI = 8'h03;
    localparam logic [7:0] SPM_REG_TMO_LO = 8'h04;
    localparam logic [7:0] SPM_REG_TMO_HI = 8'h05;
    localparam logic [7:0] SPM_REG_LIMIT = 8'h06;
    localparam logic [7:0] SPM_CH_BASE = 8'h40;
    localparam logic [2:0] SPM_CH_CFG = 3'h0;
    localparam logic [2:0] SPM_CH_A0 = 3'h1;
    localparam logic [2:0] SPM_CH_A1 = 3'h2;
    localparam logic [2:0] SPM_CH_B0 = 3'h3;
    localparam logic [2:0] SPM_CH_B1 = 3'h4;
    localparam logic [2:0] SPM_CH_TLO = 3'h5;
    localparam logic [2:0] SPM_CH_THI = 3'h6;
    localparam logic [2:0] SPM_CH_CNT = 3'h7;
    // control register bits
    localparam int unsigned SPM_CTRL_INIT = 0;
    localparam int unsigned SPM_CTRL_CANCEL = 1;
    localparam int unsigned SPM_CTRL_CANALL = 2;
    localparam int unsigned SPM_CTRL_CLRBRK = 3;
    localparam int unsigned SPM_CTRL_TMOEN = 4;
    localparam int unsigned SPM_CTRL_LIMEN = 5;
    localparam int unsigned SPM_CTRL_CHLO = 8;
    // channel config bits
    localparam int unsigned SPM_CFG_EN = 0;
    localparam int unsigned SPM_CFG_MODE = 1;
    localparam int unsigned SPM_CFG_PHYS = 3;
    localparam logic [15:0] SPM_LIMIT_MIN = 16'h0001;
    localparam logic [15:0] SPM_LIMIT_RST = 16'hFFFF;
    localparam logic [31:0] SPM_US_PER_HOUR = 32'hD693A400;
    localparam logic [31:0] SPM_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        SPM_MODE_OFF = 2'b00,
        SPM_MODE_RANGE_GATED = 2'b01,
        SPM_MODE_ENTRY_EXIT = 2'b10,
        SPM_MODE_RANGE_PAIR = 2'b11
    } spm_mode_t;

    typedef struct packed {
        logic en;
        spm_mode_t mode;
        logic phys;
        logic [SPM_ADDR_W-1:0] a0;
        logic [SPM_ADDR_W-1:0] a1;
        logic [SPM_ADDR_W-1:0] b0;
        logic [SPM_ADDR_W-1:0] b1;
    } spm_chcfg_t;

    typedef struct packed {
        logic valid;
        logic [SPM_ADDR_W-1:0] vaddr;
        logic [SPM_ADDR_W-1:0] paddr;
    } spm_fetch_t;
endpackage

// ===== test/spm_core_model.sv
// partner: target core prefetch bus and run control
`timescale 1ns/10ps
`default_nettype none
module spm_core_model
    import spm_pkg::*;
(
    // clock
    input wire logic i_clk,
    // prefetch bus and run state
    output spm_fetch_t o_fetch,
    output logic o_free_run
);
    localparam logic [31:0] PHYS_OFS = 32'h00010000;
    initial
    begin
        o_fetch = '{1'b0, 32'hFFFFFFFF, 32'hFFFFFFFF};
        o_free_run = 1'b0;
    end
    // only free run or stopped, never stepping
    task automatic go(input logic run);
        @(posedge i_clk);
        o_free_run <= run;
    endtask
    // one call of the routine, n fetches spent in a callee
    task automatic pass(input int n);
        logic [31:0] seq[$];
        seq = {32'h00000100, 32'h00000104};
        repeat (n) seq.push_back(32'h00000800);
        seq.push_back(32'h00000108);
        seq.push_back(32'h000001F0);
        seq.push_back(32'h00000300);
        foreach (seq[i])
        begin
            @(posedge i_clk);
            o_fetch <= '{1'b1, seq[i], seq[i] ^ PHYS_OFS};
        end
        @(posedge i_clk);
        o_fetch <= '{1'b0, ~o_fetch.vaddr, ~o_fetch.paddr};
    endtask
endmodule
`default_nettype wire

// ===== test/spm_monitor_sva.sv
// checker: port-level properties of the performance monitor
`timescale 1ns/10ps
`default_nettype none
module spm_monitor_sva
    import spm_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // run state
    input wire logic i_free_run,
    input wire logic i_trace_break_run_mode,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_break_req
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic rd_ok;
    logic clr_wr;
    assign rd_ok = i_rd && i_ce;
    assign clr_wr = i_wr && i_ce && i_addr == SPM_REG_CTRL && i_wdata[SPM_CTRL_CLRBRK];

    a_rdata_idle: assert property (!$past(rd_ok) |-> o_rdata == SPM_ZERO)
        else $error("read data not zero outside a read answer");
    a_stat_break: assert property (rd_ok && i_addr == SPM_REG_STAT |=> o_rdata[0] == $past(o_break_req))
        else $error("status break bit differs from break output");
    a_ctrl_readback: assert property ((i_wr && i_ce && i_addr == SPM_REG_CTRL) ##1 !i_wr
        ##1 (rd_ok && i_addr == SPM_REG_CTRL) |=> o_rdata[5:4] == $past(i_wdata[5:4], 3))
        else $error("control enables not read back");
    a_limit_nonzero: assert property (rd_ok && i_addr == SPM_REG_LIMIT |=> o_rdata[15:0] != 16'h0000)
        else $error("count limit reads zero");
    a_unmapped_zero: assert property (rd_ok && i_addr > SPM_REG_LIMIT && i_addr < SPM_CH_BASE
        |=> o_rdata == SPM_ZERO)
        else $error("unmapped read not zero");
    a_break_sticky: assert property (o_break_req && !clr_wr |=> o_break_req)
        else $error("break dropped without clear");
    a_break_needs_tb: assert property ($rose(o_break_req) |-> $past(i_trace_break_run_mode))
        else $error("break raised outside trace break run");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_break_req))
        else $error("break changed while clock enable low");
    a_total_hold: assert property (!i_free_run ##1 (rd_ok && i_addr == SPM_REG_TOT_LO && !i_free_run)
        ##1 (!i_wr && !i_free_run) ##1 (rd_ok && i_addr == SPM_REG_TOT_LO && !i_free_run)
        |=> o_rdata == $past(o_rdata, 2))
        else $error("total time moved while stopped");

    c_break: cover property ($rose(o_break_req));
    c_stat: cover property (rd_ok && i_addr == SPM_REG_STAT ##1 o_rdata[0]);
    c_total: cover property (rd_ok && i_addr == SPM_REG_TOT_LO ##1 o_rdata != SPM_ZERO);
endmodule
bind spm_monitor spm_monitor_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_free_run(i_free_run), .i_trace_break_run_mode(i_trace_break_run_mode), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_break_req(o_break_req));
`default_nettype wire

// ===== test/spm_monitor_tb.sv
// testbench: registers, measurement modes, cancel, init and breaks
`timescale 1ns/10ps
`default_nettype none
module spm_monitor_tb
    import spm_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} spm_row_t;
    logic clk;
    logic rst_n;
    logic ce;
    logic tb_mode;
    logic wr;
    logic rd;
    logic brk;
    logic free_run;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] got;
    spm_fetch_t fetch;
    int fail_count, total_checks;
    spm_row_t rows[10] = '{'{8'h41, 32'h00001234, 32'h00001234}, '{8'h79, 32'h0000ABCD, 32'h0000ABCD},
        '{8'h48, 32'h00000007, 32'h00000005}, '{8'h50, 32'h00000007, 32'h00000007},
        '{8'h06, 32'h00000005, 32'h00000005}, '{8'h06, 32'h00000000, 32'h00000005},
        '{8'h47, 32'h00000055, 32'h00000000}, '{8'h20, 32'h0000FFFF, 32'h00000000},
        '{8'h00, 32'h00000030, 32'h00000030}, '{8'h05, 32'h0001ABCD, 32'h0000ABCD}};

    always #2.5 clk = ~clk;
    spm_core_model core (.i_clk(clk), .o_fetch(fetch), .o_free_run(free_run));
    spm_monitor #(.NCH(8), .TICK_NS(5)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_fetch(fetch), .i_free_run(free_run), .i_trace_break_run_mode(tb_mode), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_break_req(brk));

    function automatic logic [7:0] ch_reg(input int n, input logic [2:0] f);
        return SPM_CH_BASE + 8'(n * 8) + {5'h00, f};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        rd_reg(a, got);
        check(got, e);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        tb_mode = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].w);
            chk_reg(rows[i].a, rows[i].e);
        end
        $display("register table done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(SPM_REG_LIMIT, 32'h0000FFFF);
        chk_reg(ch_reg(2, SPM_CH_CFG), 32'h00000000);
        wr_reg(ch_reg(0, SPM_CH_CFG), 32'h00000003);
        wr_reg(SPM_REG_CTRL, 32'h00000005);
        core.go(1'b1);
        repeat (20) @(posedge clk);
        core.go(1'b0);
        chk_reg(SPM_REG_TOT_LO, 32'h00000000);
        $display("reset and idle total done");
        for (int c = 0; c < 2; c++)
        begin
            wr_reg(ch_reg(c, SPM_CH_CFG), c ? 32'h00000005 : 32'h00000003);
            wr_reg(ch_reg(c, SPM_CH_A0), 32'h00000100);
            wr_reg(ch_reg(c, SPM_CH_A1), 32'h000001F0);
        end
        wr_reg(ch_reg(2, SPM_CH_CFG), 32'h0000000F);
        wr_reg(ch_reg(2, SPM_CH_A0), 32'h00010100);
        wr_reg(ch_reg(2, SPM_CH_A1), 32'h0001010F);
        wr_reg(ch_reg(2, SPM_CH_B0), 32'h000101F0);
        wr_reg(ch_reg(2, SPM_CH_B1), 32'h000101FF);
        core.pass(4);
        chk_reg(ch_reg(1, SPM_CH_CNT), 32'h00000000);
        core.go(1'b1);
        core.pass(6);
        core.pass(6);
        core.go(1'b0);
        repeat (2) @(posedge clk);
        chk_reg(ch_reg(0, SPM_CH_TLO), 32'h00000008);
        chk_reg(ch_reg(1, SPM_CH_TLO), 32'h00000012);
        chk_reg(ch_reg(2, SPM_CH_TLO), 32'h00000012);
        for (int c = 0; c < 3; c++)
            chk_reg(ch_reg(c, SPM_CH_CNT), 32'h00000002);
        rd_reg(SPM_REG_TOT_LO, got);
        check({31'h0, got != SPM_ZERO}, 32'h00000001);
        chk_reg(SPM_REG_TOT_LO, got);
        wr_reg(SPM_REG_CTRL, 32'h00000102);
        core.go(1'b1);
        core.pass(2);
        core.go(1'b0);
        repeat (2) @(posedge clk);
        chk_reg(ch_reg(1, SPM_CH_CNT), 32'h00000002);
        chk_reg(ch_reg(0, SPM_CH_CNT), 32'h00000003);
        wr_reg(SPM_REG_CTRL, 32'h00000001);
        for (int c = 0; c < 3; c++)
        begin
            chk_reg(ch_reg(c, SPM_CH_TLO), 32'h00000000);
            chk_reg(ch_reg(c, SPM_CH_CNT), 32'h00000000);
        end
        chk_reg(SPM_REG_TOT_LO, 32'h00000000);
        $display("modes cancel init done");
        wr_reg(SPM_REG_LIMIT, 32'h00000002);
        wr_reg(SPM_REG_CTRL, 32'h00000020);
        tb_mode <= 1'b1;
        core.go(1'b1);
        for (int p = 1; p <= 3; p++)
        begin
            core.pass(1);
            repeat (3) @(posedge clk);
            #1 check({31'h0, brk}, 32'(p == 3));
        end
        core.go(1'b0);
        chk_reg(ch_reg(0, SPM_CH_CNT), 32'h00000003);
        rd_reg(SPM_REG_STAT, got);
        check(got & 32'h00000001, 32'h00000001);
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        wr_reg(SPM_REG_CTRL, 32'h00000028);
        #1 check({31'h0, brk}, 32'h00000001);
        wr_reg(SPM_REG_CTRL, 32'h00000000);
        wr_reg(SPM_REG_CTRL, 32'h00000008);
        @(posedge clk);
        #1 check({31'h0, brk}, 32'h00000000);
        $display("count limit break done");
        wr_reg(SPM_REG_CTRL, 32'h00000001);
        wr_reg(SPM_REG_TMO_LO, 32'h00000005);
        wr_reg(ch_reg(0, SPM_CH_CFG), 32'h00000005);
        wr_reg(SPM_REG_CTRL, 32'h00000010);
        core.go(1'b1);
        core.pass(6);
        core.go(1'b0);
        repeat (2) @(posedge clk);
        #1 check({31'h0, brk}, 32'h00000001);
        chk_reg(ch_reg(0, SPM_CH_TLO), 32'h00000009);
        $display("timeout break done");
        stop_test();
    end
endmodule
`default_nettype wire
